// *** design/sodg_pkg.sv ***
// Package for the serial output datagram generator
package sodg_pkg;

    // Output format codes
    localparam logic [3:0] SODG_FMT_OFF = 4'h0;
    localparam logic [3:0] SODG_FMT_DAC_MAPPED = 4'h1;
    localparam logic [3:0] SODG_FMT_DAC_ABS_P1 = 4'h2;
    localparam logic [3:0] SODG_FMT_DAC_ABS_P0 = 4'h3;
    localparam logic [3:0] SODG_FMT_SCALE = 4'h4;
    localparam logic [3:0] SODG_FMT_CURRENT = 4'h5;
    localparam logic [3:0] SODG_FMT_DAC_SCALE = 4'h6;
    localparam logic [3:0] SODG_FMT_COVER = 4'hF;

    // Widths of the payloads
    localparam int SODG_SCALE_W = 8;
    localparam int SODG_COIL_W = 9;
    localparam int SODG_SHIFT_W = 64;
    localparam int SODG_LEN_W = 7;

    // Serial clock half period and select guard, as timer reloads: each lasts one clk cycle more
    localparam logic [7:0] SODG_HALF_CYC = 8'h04;
    localparam logic [7:0] SODG_GUARD_CYC = 8'h04;

    // Reset values
    localparam logic [7:0] SODG_SCALE_RST = 8'hFF;
    localparam logic [8:0] SODG_COIL_RST = 9'h000;

    // Configuration carried into the generator
    typedef struct packed {
        logic [3:0] format;
        logic [SODG_LEN_W-1:0] length;
        logic sck_low_before_select;
        logic launch_on_rising_edge;
    } sodg_cfg_t;

    // Frame sequencer states
    typedef enum logic [2:0] {
        SODG_IDLE = 3'b000,
        SODG_PRE = 3'b001,
        SODG_LEAD = 3'b010,
        SODG_LOW = 3'b011,
        SODG_HIGH = 3'b100,
        SODG_TAIL = 3'b101,
        SODG_POST = 3'b110
    } sodg_state_t;

    // Whole state of the generator
    typedef struct packed {
        sodg_state_t state;
        logic [7:0] timer;
        logic [SODG_LEN_W-1:0] bits_left;
        logic [SODG_SHIFT_W-1:0] shreg;
        logic [SODG_SCALE_W-1:0] scale_seen;
        logic [SODG_COIL_W-1:0] coil_a_seen;
        logic [SODG_COIL_W-1:0] coil_b_seen;
        logic pend_scale;
        logic pend_coil;
        logic pend_cover;
        logic second_b;
        logic [SODG_COIL_W-1:0] coil_b_hold;
        logic cs_n;
        logic sck;
        logic sdo;
        logic drv_en;
        logic busy;
        logic cover_done;
    } sodg_state_s_t;

endpackage

// *** design/sodg_gen.sv ***
// Serial output datagram generator for external drivers and serial DACs
//
// Operation
// [RULE1] Software sets datagram length to match the connected chip before use.
// [RULE2] Cover-only format sends cover datagrams only, no automatic value frames.
// [RULE3] Cover-only format always uses the default select and clock framing.
// [RULE4] Scale format sends 8-bit actual scale value whenever it changes.
// [RULE5] Scale frame is MSB first, leading zeros pad longer datagram lengths.
// [RULE6] Current format sends coil A above coil B as one 18-bit frame.
// [RULE7] Current frame sends bit 17 first, leading zeros pad longer lengths.
// [RULE8] Converter current formats send coil A and coil B as separate frames.
// [RULE9] Converter transfer starts when either scaled coil current changes.
// [RULE10] Coil B frame follows coil A frame automatically.
// [RULE11] Converter scale format sends a single frame only.
// [RULE12] Default: select falls, clock falls, clock rises, then select rises.
// [RULE13] Clock-low-before-select option drives clock low before select falls.
// [RULE14] By default data changes on falling clock edges.
// [RULE15] Software sets rising launch when the receiver samples on falling edge.
// [RULE16] Rising launch option changes data on rising clock edges instead.
// [RULE17] Format 1111 is cover-only, format 0000 switches output drivers off.
// [RULE18] Value changes during a frame wait until the current frame ends.
`timescale 1ns/1ps
`default_nettype none

module sodg_gen
    import sodg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire sodg_cfg_t serial_out_config,
    input wire logic [SODG_SCALE_W-1:0] actual_scale_value,
    input wire logic [SODG_COIL_W-1:0] coil_a_scaled_current,
    input wire logic [SODG_COIL_W-1:0] coil_b_scaled_current,
    input wire logic cover_start,
    input wire logic [SODG_SHIFT_W-1:0] cover_data,
    output logic out_chip_select_n,
    output logic out_serial_clock,
    output logic out_serial_data,
    output logic out_drive_enable,
    output logic busy,
    output logic cover_done
);

    // ****************************************************************
    // Format decode
    // ****************************************************************

    logic fmt_cover;
    logic fmt_off;
    logic fmt_dac_pair;
    logic fmt_scale;
    logic use_sck_low;
    logic rise_launch;

    // Cover-only and off restrict what may be sent and how
    assign fmt_cover = (serial_out_config.format == SODG_FMT_COVER); // [RULE17]
    assign fmt_off = (serial_out_config.format == SODG_FMT_OFF); // [RULE17]
    assign fmt_dac_pair = (serial_out_config.format == SODG_FMT_DAC_MAPPED)
        || (serial_out_config.format == SODG_FMT_DAC_ABS_P1)
        || (serial_out_config.format == SODG_FMT_DAC_ABS_P0);
    assign fmt_scale = (serial_out_config.format == SODG_FMT_SCALE)
        || (serial_out_config.format == SODG_FMT_DAC_SCALE);
    // Alternative framing is masked in cover-only format
    assign use_sck_low = serial_out_config.sck_low_before_select
        && !fmt_cover; // [RULE3]
    assign rise_launch = serial_out_config.launch_on_rising_edge
        && !fmt_cover; // [RULE3]

    // ****************************************************************
    // State registers
    // ****************************************************************

    sodg_state_s_t st_r;
    sodg_state_s_t st_nxt;

    // Right-aligned payload placed so its MSB leaves first
    function automatic logic [SODG_SHIFT_W-1:0] align_msb(
        input logic [SODG_SHIFT_W-1:0] val,
        input logic [SODG_LEN_W-1:0] len
    );
        logic [SODG_SHIFT_W-1:0] r;
        r = val << (7'(SODG_SHIFT_W) - len);
        return r;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.cover_done = 1'b0;
        st_nxt.drv_en = !fmt_off; // [RULE17]

        case (st_r.state)
            SODG_IDLE:
            begin
                st_nxt.cs_n = 1'b1;
                st_nxt.sck = !use_sck_low; // [RULE13]
                st_nxt.busy = 1'b0;
                st_nxt.timer = SODG_GUARD_CYC;
                st_nxt.bits_left = serial_out_config.length;
                // New frames only start here, never mid-frame
                if (fmt_off || serial_out_config.length == '0)
                begin
                    st_nxt.pend_cover = 1'b0;
                end
                else if (st_r.second_b)
                begin
                    // Coil B follows coil A with no new trigger
                    st_nxt.second_b = 1'b0; // [RULE10]
                    st_nxt.shreg = align_msb(
                        SODG_SHIFT_W'(st_r.coil_b_hold),
                        serial_out_config.length); // [RULE8]
                    st_nxt.state = SODG_PRE;
                    st_nxt.busy = 1'b1;
                end
                else if (st_r.pend_cover)
                begin
                    st_nxt.pend_cover = 1'b0;
                    st_nxt.shreg = cover_data;
                    st_nxt.state = SODG_PRE;
                    st_nxt.busy = 1'b1;
                end
                else if (st_r.pend_coil)
                begin
                    st_nxt.pend_coil = 1'b0;
                    st_nxt.busy = 1'b1;
                    st_nxt.state = SODG_PRE;
                    if (fmt_dac_pair)
                    begin
                        st_nxt.shreg = align_msb(
                            SODG_SHIFT_W'(st_r.coil_a_seen),
                            serial_out_config.length); // [RULE8]
                        st_nxt.coil_b_hold = st_r.coil_b_seen;
                        st_nxt.second_b = 1'b1; // [RULE10]
                    end
                    else
                    begin
                        st_nxt.shreg = align_msb(SODG_SHIFT_W'(
                            {st_r.coil_a_seen, st_r.coil_b_seen}),
                            serial_out_config.length); // [RULE6] [RULE7]
                    end
                end
                else if (st_r.pend_scale)
                begin
                    st_nxt.pend_scale = 1'b0;
                    // One frame only, zeros ahead of bit 7
                    st_nxt.shreg = align_msb(
                        SODG_SHIFT_W'(st_r.scale_seen),
                        serial_out_config.length); // [RULE5] [RULE11]
                    st_nxt.state = SODG_PRE;
                    st_nxt.busy = 1'b1;
                end
            end
            SODG_PRE:
            begin
                // Select falls; clock already low if option set
                st_nxt.cs_n = 1'b0; // [RULE12] [RULE13]
                st_nxt.sdo = st_r.shreg[SODG_SHIFT_W-1];
                st_nxt.state = SODG_LEAD;
            end
            SODG_LEAD:
            begin
                if (st_r.timer == 8'h00)
                begin
                    st_nxt.timer = SODG_HALF_CYC;
                    st_nxt.sck = 1'b0; // [RULE12]
                    st_nxt.state = SODG_LOW;
                end
                else
                begin
                    st_nxt.timer = st_r.timer - 8'h01;
                end
            end
            SODG_LOW:
            begin
                if (st_r.timer == 8'h00)
                begin
                    st_nxt.timer = SODG_HALF_CYC;
                    st_nxt.sck = 1'b1;
                    st_nxt.state = SODG_HIGH;
                    st_nxt.bits_left = st_r.bits_left - 7'h01;
                    if (rise_launch)
                    begin
                        // Next bit leaves on the rising edge
                        st_nxt.shreg = st_r.shreg << 1; // [RULE16]
                        st_nxt.sdo = st_r.shreg[SODG_SHIFT_W-2];
                    end
                end
                else
                begin
                    st_nxt.timer = st_r.timer - 8'h01;
                end
            end
            SODG_HIGH:
            begin
                if (st_r.timer == 8'h00)
                begin
                    st_nxt.timer = SODG_HALF_CYC;
                    if (st_r.bits_left == '0)
                    begin
                        // Clock stays high before select rises
                        st_nxt.timer = SODG_GUARD_CYC;
                        st_nxt.state = SODG_TAIL; // [RULE12]
                    end
                    else
                    begin
                        st_nxt.sck = 1'b0;
                        st_nxt.state = SODG_LOW;
                        if (!rise_launch)
                        begin
                            // Data changes on the falling edge
                            st_nxt.shreg = st_r.shreg << 1; // [RULE14]
                            st_nxt.sdo = st_r.shreg[SODG_SHIFT_W-2];
                        end
                    end
                end
                else
                begin
                    st_nxt.timer = st_r.timer - 8'h01;
                end
            end
            SODG_TAIL:
            begin
                if (st_r.timer == 8'h00)
                begin
                    st_nxt.cs_n = 1'b1; // [RULE12]
                    st_nxt.timer = SODG_GUARD_CYC;
                    st_nxt.state = SODG_POST;
                end
                else
                begin
                    st_nxt.timer = st_r.timer - 8'h01;
                end
            end
            SODG_POST:
            begin
                // Guard keeps back-to-back frames apart
                if (st_r.timer == 8'h00)
                begin
                    st_nxt.state = SODG_IDLE; // [RULE18]
                    st_nxt.cover_done = 1'b1;
                    st_nxt.sdo = 1'b0;
                end
                else
                begin
                    st_nxt.timer = st_r.timer - 8'h01;
                end
            end
            default:
            begin
                st_nxt.state = SODG_IDLE;
            end
        endcase

        // Change detection after the sequencer, so a change in the
        // cycle a frame is served stays pending instead of being lost
        if (actual_scale_value != st_r.scale_seen)
        begin
            st_nxt.scale_seen = actual_scale_value;
            if (fmt_scale)
            begin
                st_nxt.pend_scale = 1'b1; // [RULE4]
            end
        end
        if ((coil_a_scaled_current != st_r.coil_a_seen)
            || (coil_b_scaled_current != st_r.coil_b_seen))
        begin
            st_nxt.coil_a_seen = coil_a_scaled_current;
            st_nxt.coil_b_seen = coil_b_scaled_current;
            if (fmt_dac_pair
                || (serial_out_config.format == SODG_FMT_CURRENT))
            begin
                st_nxt.pend_coil = 1'b1; // [RULE9]
            end
        end
        if (cover_start)
        begin
            st_nxt.pend_cover = 1'b1;
        end
        // Cover-only and off suppress automatic frames
        if (fmt_cover || fmt_off)
        begin
            st_nxt.pend_scale = 1'b0; // [RULE2]
            st_nxt.pend_coil = 1'b0; // [RULE2]
        end
        // Off format drops cover requests as well
        if (fmt_off)
        begin
            st_nxt.pend_cover = 1'b0; // [RULE17]
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Seen values reset to defaults so no spurious frame at start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '{state: SODG_IDLE, timer: 8'h00, bits_left: '0,
                shreg: '0, scale_seen: SODG_SCALE_RST,
                coil_a_seen: SODG_COIL_RST, coil_b_seen: SODG_COIL_RST,
                pend_scale: 1'b0, pend_coil: 1'b0, pend_cover: 1'b0,
                second_b: 1'b0, coil_b_hold: SODG_COIL_RST, cs_n: 1'b1,
                sck: 1'b1, sdo: 1'b0, drv_en: 1'b0, busy: 1'b0,
                cover_done: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All straight from flip-flops
    assign out_chip_select_n = st_r.cs_n;
    assign out_serial_clock = st_r.sck;
    assign out_serial_data = st_r.sdo;
    assign out_drive_enable = st_r.drv_en;
    assign busy = st_r.busy;
    assign cover_done = st_r.cover_done;

endmodule

`default_nettype wire

// *** testbench/sodg_gen_asserts.sv ***
// Checker of framing and edge relations at the generator ports
`timescale 1ns/1ps
`default_nettype none

module sodg_gen_asserts
    import sodg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire sodg_cfg_t serial_out_config,
    input wire logic out_chip_select_n,
    input wire logic out_serial_clock,
    input wire logic out_serial_data,
    input wire logic out_drive_enable,
    input wire logic busy,
    input wire logic cover_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic cs;
    logic sck;
    logic isf;
    logic dflt;
    logic rise;
    // Cover format forces default framing, so options count only elsewhere
    assign cs = out_chip_select_n;
    assign sck = out_serial_clock;
    assign isf = serial_out_config.format == SODG_FMT_COVER;
    assign dflt = !serial_out_config.sck_low_before_select || isf;
    assign rise = serial_out_config.launch_on_rising_edge && !isf;

    property p_off;
        serial_out_config.format == SODG_FMT_OFF |=> !out_drive_enable;
    endproperty
    a_off: assert property (p_off) else $error("drivers on in off format");
    property p_lead;
        $fell(cs) && dflt |-> sck [*5];
    endproperty
    a_lead: assert property (p_lead) else $error("clock not idle high");
    property p_tail;
        $rose(cs) && dflt |-> sck && $past(sck);
    endproperty
    a_tail: assert property (p_tail) else $error("select rose first");
    property p_low;
        $fell(cs) && !dflt |-> !$past(sck);
    endproperty
    a_low: assert property (p_low) else $error("clock not low first");
    property p_cover;
        $fell(cs) && isf |-> sck;
    endproperty
    a_cover: assert property (p_cover) else $error("cover framing");
    property p_fall;
        $changed(out_serial_data) && !cs && !$past(cs) && !rise && dflt
            |-> $fell(sck);
    endproperty
    a_fall: assert property (p_fall) else $error("data off fall");
    property p_rise;
        $changed(out_serial_data) && !cs && !$past(cs) && rise && dflt
            |-> $rose(sck);
    endproperty
    a_rise: assert property (p_rise) else $error("data off rise");
    property p_gap;
        $rose(cs) |-> cs [*6];
    endproperty
    a_gap: assert property (p_gap) else $error("frames overlap");
    // A selected frame is always reported as busy
    property p_busy;
        !cs |-> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("frame not busy");
    // Frame end pulse follows the select guard by a fixed delay
    property p_done;
        $rose(cs) |-> ##5 cover_done ##1 !cover_done;
    endproperty
    a_done: assert property (p_done) else $error("end pulse");
endmodule

bind sodg_gen sodg_gen_asserts sodg_gen_asserts_inst (.clk(clk),
    .rst_b(rst_b), .serial_out_config(serial_out_config),
    .out_chip_select_n(out_chip_select_n),
    .out_serial_clock(out_serial_clock),
    .out_serial_data(out_serial_data),
    .out_drive_enable(out_drive_enable), .busy(busy),
    .cover_done(cover_done));

`default_nettype wire

// *** testbench/sodg_rx_model.sv ***
// Behavioural serial receiver at the far end of the output
`timescale 1ns/1ps
`default_nettype none

module sodg_rx_model
(
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdo,
    input wire logic fall,
    output logic [63:0] rx_word,
    output logic [7:0] rx_bits,
    output logic [15:0] rx_count
);
    logic [63:0] sh;
    logic [7:0] n;
    // New frame clears the shifter
    always @(negedge cs_n)
    begin
        sh = '0;
        n = '0;
    end
    // Sample on rise, or on fall when launched on rise
    always @(sck)
        if (!cs_n && sck !== fall)
        begin
            sh = {sh[62:0], sdo};
            n = n + 8'h01;
        end
    // Frame is handed over when select rises
    always @(posedge cs_n or negedge rst_b)
        if (!rst_b)
        begin
            rx_count <= '0;
            rx_word <= '0;
            rx_bits <= '0;
        end
        else
        begin
            rx_count <= rx_count + 16'h0001;
            rx_word <= sh;
            rx_bits <= n;
        end
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking testbench for the serial output datagram generator
`timescale 1ns/1ps
`default_nettype none

module tb;
    import sodg_pkg::*;
    logic clk, rst_b, cst, cs_n, sck, sdo, den, busy, done;
    sodg_cfg_t cfg;
    logic [7:0] scl;
    logic [8:0] ca, cb;
    logic [63:0] cdat, w, e1, rxw;
    logic [7:0] rxb;
    logic [15:0] rxc, base;
    int errors, n_tests, k, len;

    always #12.5 clk = ~clk;

    sodg_gen sodg_gen_inst (.clk(clk), .rst_b(rst_b),
        .serial_out_config(cfg), .actual_scale_value(scl),
        .coil_a_scaled_current(ca), .coil_b_scaled_current(cb),
        .cover_start(cst), .cover_data(cdat),
        .out_chip_select_n(cs_n), .out_serial_clock(sck),
        .out_serial_data(sdo), .out_drive_enable(den),
        .busy(busy), .cover_done(done));
    // Receiver edge follows the launch option
    sodg_rx_model sodg_rx_model_inst (.rst_b(rst_b), .cs_n(cs_n),
        .sck(sck), .sdo(sdo), .fall(cfg.launch_on_rising_edge),
        .rx_word(rxw), .rx_bits(rxb), .rx_count(rxc));

    function automatic logic [63:0] cur(logic [8:0] a, logic [8:0] b);
        return {46'h0, a, b};
    endfunction
    function automatic logic [63:0] cov(logic [63:0] d, int l);
        return d >> (64 - l);
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %0t: seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Step past edges so register outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // New setting, then drain any frame it may set off
    task automatic setup(input logic [3:0] f, input int l, input logic lo,
        input logic ri);
        int i;
        @(posedge clk) cfg <= '{f, l[6:0], lo, ri};
        tick(900);
        for (i = 0; i < 2000 && busy !== 1'b0; i++)
            tick(1);
        tick(20);
        base = rxc;
    endtask
    task automatic get(output logic [63:0] f);
        int i;
        for (i = 0; i < 3000 && rxc == base; i++)
            tick(1);
        if (rxc == base)
        begin
            errors++;
            $display("MISMATCH %0t: no frame", $time);
        end
        base = rxc;
        f = rxw;
    endtask

    // Watchdog: far beyond the expected run length
    initial
    begin
        #2000000;
        errors++;
        $display("MISMATCH %0t: watchdog", $time);
        summarize();
    end

    initial
    begin
        clk = 0; rst_b = 0; cst = 0; cdat = '0; scl = 8'hFF;
        ca = '0; cb = '0; errors = 0; n_tests = 0; base = '0;
        cfg = '{SODG_FMT_OFF, 7'h08, 1'b0, 1'b0};
        void'($urandom(21));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        tick(3);
        check(den, 1'b0);
        @(posedge clk) scl <= 8'h5A;
        tick(1500);
        check(rxc, base);
        $display("off test done");
        // Scale frames, both length corners and both launch edges
        for (k = 0; k < 6; k++)
        begin
            len = (k == 0) ? 8 : (k == 1) ? 64 : 9 + $urandom % 50;
            setup(SODG_FMT_SCALE, len, 1'b0, k[0]);
            @(posedge clk) scl <= scl ^ 8'(1 + $urandom % 255);
            get(w);
            check(w, 64'(scl));
            check(rxb, len[7:0]);
        end
        $display("scale test done");
        for (k = 0; k < 3; k++)
        begin
            setup(SODG_FMT_CURRENT, (k == 0) ? 18 : 19 + $urandom % 40,
                1'b0, 1'b0);
            @(posedge clk)
            begin
                ca <= ca ^ 9'(1 + $urandom % 511);
                cb <= cb ^ 9'(1 + $urandom % 511);
            end
            get(w);
            check(w, cur(ca, cb));
        end
        $display("current test done");
        // Converter formats, triggered by coil A then by coil B
        for (k = 0; k < 6; k++)
        begin
            setup(4'(1 + k % 3), 9 + $urandom % 12, 1'b0, 1'b0);
            @(posedge clk)
                if (k < 3)
                    ca <= ca ^ 9'(1 + $urandom % 511);
                else
                    cb <= cb ^ 9'(1 + $urandom % 511);
            get(w);
            check(w, 64'(ca));
            get(w);
            check(w, 64'(cb));
        end
        $display("converter test done");
        setup(SODG_FMT_DAC_SCALE, 12, 1'b0, 1'b0);
        @(posedge clk) scl <= ~scl;
        get(w);
        check(w, 64'(scl));
        tick(1500);
        check(rxc, base);
        $display("converter scale test done");
        setup(SODG_FMT_COVER, 20, 1'b1, 1'b0);
        check(den, 1'b1);
        @(posedge clk) scl <= ~scl;
        tick(1500);
        check(rxc, base);
        @(posedge clk)
        begin
            cdat <= {$urandom, $urandom};
            cst <= 1'b1;
        end
        @(posedge clk) cst <= 1'b0;
        get(w);
        check(w, cov(cdat, 20));
        $display("cover test done");
        // Change in mid-frame is held back for the next frame
        setup(SODG_FMT_CURRENT, 40, 1'b0, 1'b0);
        @(posedge clk) ca <= ~ca;
        tick(100);
        check(busy, 1'b1);
        e1 = cur(ca, cb);
        @(posedge clk) ca <= ca + 9'h001;
        get(w);
        check(w, e1);
        get(w);
        check(w, cur(ca, cb));
        $display("mid-frame test done");
        setup(SODG_FMT_SCALE, 8, 1'b1, 1'b0);
        @(posedge clk) scl <= ~scl;
        tick(900);
        check(rxc, base + 16'h0001);
        check(rxw, 64'(scl));
        $display("clock-low test done");
        summarize();
    end
endmodule

`default_nettype wire
